// File: src/fm_pkg.sv
package fm_pkg;
    localparam int unsigned MEM_DEPTH = 32768;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int SEL_W = 3;
    localparam int TYPE_W = 4;
    // Device type code value is arbitrary
    localparam logic [3:0] TYPE_CODE = 4'h6;
    localparam int DEV_TYPE_LSB = 4;
    localparam int DEV_SEL_LSB = 1;
    localparam int DEV_RW_BIT = 0;
    localparam int ADDR_HI_LSB = 8;
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;
    localparam logic [3:0] BIT_CNT_RST = 4'h0;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [14:0] ADDR_RST = 15'h0000;
    localparam logic [14:0] ADDR_STEP = 15'h0001;
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic [5:0] PINS_RST = 6'h30;
    localparam logic [1:0] DRV_RST = 2'h1;
    localparam logic OE_N_DRIVE = 1'b0;
    localparam logic OE_N_RELEASE = 1'b1;

    typedef struct packed {
        logic scl;
        logic sda;
        logic wp;
        logic select_pin_2;
        logic select_pin_1;
        logic select_pin_0;
    } fm_pins_t;

    typedef struct packed {
        logic sda_out;
        logic sda_oe_n;
    } fm_sda_drv_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_RX = 5'b00010,
        ST_RX_ACK = 5'b00100,
        ST_TX = 5'b01000,
        ST_TX_ACK = 5'b10000
    } fm_state_t;

    typedef enum logic [3:0] {
        K_DEV = 4'b0001,
        K_ADDR_HI = 4'b0010,
        K_ADDR_LO = 4'b0100,
        K_DATA = 4'b1000
    } fm_kind_t;
endpackage

// File: src/fm_i2c_slave.sv
`timescale 1ns/100ps
`default_nettype none
module fm_i2c_slave (
    input wire logic clk,
    input wire logic sys_rst,
    input wire fm_pkg::fm_pins_t pins_in,
    output var fm_pkg::fm_sda_drv_t sda_drv_reg,
    output logic selected_reg
);
    import fm_pkg::*;

    fm_pins_t pin_s1_reg;
    fm_pins_t pin_s2_reg;
    fm_pins_t pin_s3_reg;
    fm_pins_t pin_f_reg;
    fm_pins_t pin_next;
    fm_state_t state_reg;
    fm_kind_t kind_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic rw_reg;
    logic acked_reg;
    logic [14:0] addr_reg;
    logic [7:0] mem [0:MEM_DEPTH-1];
    logic [7:0] mem_rd;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic bus_ev;
    logic rx_done;
    logic tx_done;
    logic mem_we;

    function automatic logic dev_match(input logic [7:0] word, input fm_pins_t p);
        logic [2:0] sel;
        sel = {p.select_pin_2, p.select_pin_1, p.select_pin_0};
        dev_match = (word[DEV_TYPE_LSB +: TYPE_W] == TYPE_CODE) && (word[DEV_SEL_LSB +: SEL_W] == sel);
    endfunction

    function automatic fm_kind_t next_kind(input fm_kind_t k);
        case (k)
            K_DEV: next_kind = K_ADDR_HI;
            K_ADDR_HI: next_kind = K_ADDR_LO;
            default: next_kind = K_DATA;
        endcase
    endfunction

    // Three-stage sampling; a level is taken only once stages two and three agree
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_s1_reg <= PINS_RST;
            pin_s2_reg <= PINS_RST;
            pin_s3_reg <= PINS_RST;
            pin_f_reg <= PINS_RST;
        end
        else
        begin
            pin_s1_reg <= pins_in;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_f_reg <= pin_next;
        end
    end

    // Open pins are pulled low outside, so plain levels suffice here
    always_comb
    begin
        pin_next = (pin_s2_reg & ~(pin_s2_reg ^ pin_s3_reg)) | (pin_f_reg & (pin_s2_reg ^ pin_s3_reg));
    end

    // Bus events; the clock is only ever observed, never driven
    assign scl_rise = pin_next.scl & ~pin_f_reg.scl;
    assign scl_fall = ~pin_next.scl & pin_f_reg.scl;
    assign start_ev = pin_f_reg.scl & pin_next.scl & pin_f_reg.sda & ~pin_next.sda;
    assign stop_ev = pin_f_reg.scl & pin_next.scl & ~pin_f_reg.sda & pin_next.sda;
    assign bus_ev = start_ev | stop_ev;
    assign rx_done = (state_reg == ST_RX) && scl_fall && (bit_cnt_reg == BYTE_BITS) && !bus_ev;
    assign tx_done = (state_reg == ST_TX) && scl_fall && (bit_cnt_reg == BYTE_BITS) && !bus_ev;
    assign mem_we = rx_done && (kind_reg == K_DATA) && !pin_f_reg.wp;
    assign mem_rd = mem[addr_reg];

    // Protocol sequencer; outgoing line only moves on a clock fall or a bus event
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg <= ST_IDLE;
            kind_reg <= K_DEV;
            bit_cnt_reg <= BIT_CNT_RST;
            shift_reg <= SHIFT_RST;
            rw_reg <= RW_WRITE;
            acked_reg <= 1'b0;
            sda_drv_reg <= DRV_RST;
        end
        else if (stop_ev)
        begin
            state_reg <= ST_IDLE;
            sda_drv_reg.sda_oe_n <= OE_N_RELEASE;
        end
        else if (start_ev)
        begin
            state_reg <= ST_RX;
            kind_reg <= K_DEV;
            bit_cnt_reg <= BIT_CNT_RST;
            sda_drv_reg.sda_oe_n <= OE_N_RELEASE;
        end
        else
        begin
            sda_drv_reg.sda_out <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    bit_cnt_reg <= BIT_CNT_RST;
                end
                ST_RX:
                begin
                    if (scl_rise && bit_cnt_reg != BYTE_BITS)
                    begin
                        shift_reg <= {shift_reg[6:0], pin_next.sda};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (rx_done)
                    begin
                        if (kind_reg != K_DEV || dev_match(shift_reg, pin_f_reg))
                        begin
                            sda_drv_reg.sda_oe_n <= OE_N_DRIVE;
                            state_reg <= ST_RX_ACK;
                            if (kind_reg == K_DEV)
                            begin
                                rw_reg <= shift_reg[DEV_RW_BIT];
                            end
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_RX_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_reg <= BIT_CNT_RST;
                        if (kind_reg == K_DEV && rw_reg == RW_READ)
                        begin
                            shift_reg <= {mem_rd[6:0], 1'b0};
                            sda_drv_reg.sda_oe_n <= mem_rd[7];
                            state_reg <= ST_TX;
                        end
                        else
                        begin
                            sda_drv_reg.sda_oe_n <= OE_N_RELEASE;
                            kind_reg <= next_kind(kind_reg);
                            state_reg <= ST_RX;
                        end
                    end
                end
                ST_TX:
                begin
                    if (scl_rise)
                    begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end
                    else if (tx_done)
                    begin
                        sda_drv_reg.sda_oe_n <= OE_N_RELEASE;
                        bit_cnt_reg <= BIT_CNT_RST;
                        acked_reg <= 1'b0;
                        state_reg <= ST_TX_ACK;
                    end
                    else if (scl_fall)
                    begin
                        sda_drv_reg.sda_oe_n <= shift_reg[7];
                        shift_reg <= {shift_reg[6:0], 1'b0};
                    end
                end
                ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        acked_reg <= ~pin_next.sda;
                    end
                    else if (scl_fall)
                    begin
                        if (acked_reg)
                        begin
                            shift_reg <= {mem_rd[6:0], 1'b0};
                            sda_drv_reg.sda_oe_n <= mem_rd[7];
                            state_reg <= ST_TX;
                        end
                        else
                        begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default:
                begin
                    state_reg <= ST_IDLE;
                    sda_drv_reg.sda_oe_n <= OE_N_RELEASE;
                end
            endcase
        end
    end

    // Address counter; it advances even on a protected write so page order is kept
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_reg <= ADDR_RST;
        end
        else if (rx_done && kind_reg == K_ADDR_HI)
        begin
            addr_reg[ADDR_W-1:ADDR_HI_LSB] <= shift_reg[ADDR_W-1-ADDR_HI_LSB:0];
        end
        else if (rx_done && kind_reg == K_ADDR_LO)
        begin
            addr_reg[ADDR_HI_LSB-1:0] <= shift_reg;
        end
        else if ((rx_done && kind_reg == K_DATA) || tx_done)
        begin
            addr_reg <= addr_reg + ADDR_STEP;
        end
    end

    // Array is not reset; contents are nonvolatile in spirit
    always_ff @(posedge clk)
    begin
        if (mem_we)
        begin
            mem[addr_reg] <= shift_reg;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            selected_reg <= 1'b0;
        end
        else
        begin
            selected_reg <= (state_reg != ST_IDLE);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_byte_in;
        (state_reg == ST_RX) && rx_done;
    endsequence

    sequence s_ack_phase;
        (state_reg == ST_RX_ACK) && (sda_drv_reg.sda_oe_n == OE_N_DRIVE);
    endsequence

    property p_open_drain;
        sda_drv_reg.sda_out == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("data line driven high");

    property p_idle_released;
        (state_reg == ST_IDLE) |-> (sda_drv_reg.sda_oe_n == OE_N_RELEASE);
    endproperty
    a_idle_released: assert property (p_idle_released) else $error("line pulled while idle");

    property p_mismatch_idle;
        s_byte_in ##0 (kind_reg == K_DEV) ##0 !dev_match(shift_reg, pin_f_reg) |=> (state_reg == ST_IDLE);
    endproperty
    a_mismatch_idle: assert property (p_mismatch_idle) else $error("foreign address accepted");

    property p_ack_after_byte;
        s_byte_in ##0 (kind_reg != K_DEV) |=> s_ack_phase;
    endproperty
    a_ack_after_byte: assert property (p_ack_after_byte) else $error("byte not acknowledged");

    property p_change_on_fall;
        $changed(sda_drv_reg.sda_oe_n) |-> $past(scl_fall || start_ev || stop_ev);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall) else $error("line changed off clock fall");

    property p_stop_idle;
        stop_ev |=> (state_reg == ST_IDLE) ##1 (sda_drv_reg.sda_oe_n == OE_N_RELEASE);
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

    property p_start_restart;
        start_ev |=> (state_reg == ST_RX) && (kind_reg == K_DEV) && (bit_cnt_reg == BIT_CNT_RST);
    endproperty
    a_start_restart: assert property (p_start_restart) else $error("start did not restart");

    property p_wp_blocks;
        pin_f_reg.wp |-> !mem_we;
    endproperty
    a_wp_blocks: assert property (p_wp_blocks) else $error("write under protect");

    property p_read_continues;
        (state_reg == ST_TX_ACK) && scl_fall && acked_reg && !bus_ev |=> (state_reg == ST_TX);
    endproperty
    a_read_continues: assert property (p_read_continues) else $error("read stalled");

    // The pull must survive the master's sampling rise; only the following fall may end it
    property p_ack_held;
        s_ack_phase ##0 scl_rise |=> (state_reg == ST_RX_ACK) && (sda_drv_reg.sda_oe_n == OE_N_DRIVE);
    endproperty
    a_ack_held: assert property (p_ack_held) else $error("ack released early");

    property p_addr_advance;
        s_byte_in ##0 (kind_reg == K_DATA) |=> (addr_reg == $past(addr_reg) + ADDR_STEP);
    endproperty
    a_addr_advance: assert property (p_addr_advance) else $error("address did not advance");

    property p_dir_latched;
        s_byte_in ##0 (kind_reg == K_DEV) ##0 dev_match(shift_reg, pin_f_reg) |=> (rw_reg == $past(shift_reg[DEV_RW_BIT]));
    endproperty
    a_dir_latched: assert property (p_dir_latched) else $error("direction bit not taken");
endmodule
`default_nettype wire

// File: verification/fm_bus_master.sv
`timescale 1ns/100ps
`default_nettype none
module fm_bus_master (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl,
    output logic sda_m
);
    // Clock stands high between frames; only this side ever moves it
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One clock period of 8 cycles; data is sampled late in the high phase because the slave answers late
    task automatic clk_bit(input logic v, output logic s);
        tick(2);
        sda_m <= v;
        tick(2);
        scl <= 1'b1;
        tick(3);
        @(negedge clk) s = sda_line;
        @(posedge clk) scl <= 1'b0;
    endtask
    task automatic i2c_start();
        tick(2);
        sda_m <= 1'b1;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b0;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic i2c_stop();
        tick(2);
        sda_m <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(4);
        sda_m <= 1'b1;
        tick(4);
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
    task automatic get_byte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
            clk_bit(1'b1, d[i]);
        clk_bit(last, s);
    endtask
endmodule
`default_nettype wire

// File: verification/fm_i2c_slave_test.sv
`timescale 1ns/100ps
`default_nettype none
module fm_i2c_slave_test;
    import fm_pkg::*;
    typedef struct packed {
        logic wp;
        logic [2:0] strap;
        logic [2:0] sel;
        logic [14:0] addr;
        logic [7:0] data;
        logic ack;
    } fm_row_t;
    logic clk;
    logic sys_rst = 1'b1;
    logic wp = 1'b0;
    logic [2:0] strap = 3'h0;
    logic scl;
    logic sda_m;
    logic sda_line;
    logic selected;
    fm_pins_t pins;
    fm_sda_drv_t drv;
    int mismatches = 0;
    int checked = 0;
    logic [7:0] mem [logic [14:0]];
    fm_row_t rows [5] = '{'{1'b0, 3'h5, 3'h5, 15'h0000, 8'ha5, 1'b1}, '{1'b1, 3'h5, 3'h5, 15'h0000, 8'h3c, 1'b1},
        '{1'b0, 3'h2, 3'h3, 15'h0100, 8'h77, 1'b0}, '{1'b0, 3'h0, 3'h0, 15'h7fff, 8'h81, 1'b1},
        '{1'b0, 3'h7, 3'h7, 15'h1234, 8'h5a, 1'b1}};
    // Pull-up on the data line: released means high
    assign sda_line = sda_m & (drv.sda_oe_n | drv.sda_out);
    assign pins = {scl, sda_line, wp, strap};
    fm_i2c_slave dut (.clk(clk), .sys_rst(sys_rst), .pins_in(pins), .sda_drv_reg(drv), .selected_reg(selected));
    fm_bus_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(negedge clk)
        if (drv.sda_oe_n === 1'b0 && drv.sda_out !== 1'b0)
            check(8'(drv.sda_out), 8'h0);
    initial
    begin
        repeat (100000) @(posedge clk);
        mismatches++;
        give_verdict();
    end
    task automatic wait_idle();
        int n;
        n = 0;
        while (selected !== 1'b0 && n < 20)
        begin
            @(negedge clk);
            n++;
        end
        check(8'(selected), 8'h0);
        // A slave that never goes idle would stall every later frame
        if (selected !== 1'b0)
            give_verdict();
    endtask
    task automatic addr_phase(input logic [2:0] sel, input logic [14:0] a, output logic ack);
        logic k1;
        logic k2;
        logic k3;
        m.i2c_start();
        m.put_byte({TYPE_CODE, sel, RW_WRITE}, k1);
        m.put_byte({1'b0, a[14:8]}, k2);
        m.put_byte(a[7:0], k3);
        ack = k1 & k2 & k3;
    endtask
    task automatic write_bytes(input logic [2:0] sel, input logic [14:0] a, input logic [7:0] d0,
        input logic [7:0] d1, input int n, input logic exp);
        logic k;
        logic [14:0] ai;
        addr_phase(sel, a, k);
        check(8'(k), 8'(exp));
        for (int i = 0; i < n; i++)
        begin
            ai = a + 15'(i);
            m.put_byte(i == 0 ? d0 : d1, k);
            check(8'(k), 8'(exp));
            if (exp && !wp)
                mem[ai] = i == 0 ? d0 : d1;
        end
        m.i2c_stop();
        wait_idle();
    endtask
    task automatic read_bytes(input logic [2:0] sel, input logic [14:0] a, input int n);
        logic k;
        logic [7:0] d;
        logic [14:0] ai;
        addr_phase(sel, a, k);
        m.i2c_start();
        m.put_byte({TYPE_CODE, sel, RW_READ}, k);
        check(8'(k), 8'h1);
        for (int i = 0; i < n; i++)
        begin
            ai = a + 15'(i);
            m.get_byte(i == n - 1, d);
            check(d, mem[ai]);
        end
        m.i2c_stop();
        wait_idle();
    endtask
    initial
    begin
        logic k;
        logic [7:0] d;
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        check(8'({drv.sda_oe_n, drv.sda_out, selected}), 8'h4);
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            @(posedge clk);
            wp <= rows[i].wp;
            strap <= rows[i].strap;
            write_bytes(rows[i].sel, rows[i].addr, rows[i].data, 8'h00, 1, rows[i].ack);
            if (rows[i].ack)
                read_bytes(rows[i].sel, rows[i].addr, 1);
        end
        // Page write across the top address wraps to zero
        @(posedge clk);
        strap <= 3'h5;
        write_bytes(3'h5, 15'h7fff, 8'h11, 8'h22, 2, 1'b1);
        read_bytes(3'h5, 15'h7fff, 2);
        // Foreign type code is never answered
        m.i2c_start();
        m.put_byte({~TYPE_CODE, 3'h5, RW_READ}, k);
        check(8'(k), 8'h0);
        m.i2c_stop();
        wait_idle();
        // Start in mid byte throws the partial byte away
        addr_phase(3'h5, 15'h0000, k);
        check(8'({k, selected}), 8'h3);
        m.clk_bit(1'b1, k);
        m.clk_bit(1'b0, k);
        m.clk_bit(1'b1, k);
        m.i2c_start();
        m.put_byte({TYPE_CODE, 3'h5, RW_READ}, k);
        check(8'(k), 8'h1);
        m.get_byte(1'b1, d);
        check(d, mem[15'h0000]);
        m.i2c_stop();
        wait_idle();
        give_verdict();
    end
endmodule
`default_nettype wire
